// ### design/pmv_clkdiv.sv
/*
 * CPU clock prescaler: one tick every 2, or 4/8/16/32 oscillator cycles.
 * Assumes the divisor changes only at a tick boundary.
 */
`timescale 1ns/100ps
`default_nettype none
`include "pmv_defs.svh"
module pmv_clkdiv (
    input  wire logic   i_clk_sys,  // Oscillator clock
    input  wire logic   i_rst,      // Async reset
    input  wire logic   i_ce,       // Clock enable
    pmv_clkdiv_if.div   bus         // Controller side
);
    logic [4:0] cnt_reg;
    logic [4:0] lim_reg;
    logic [4:0] lim_next;

    // ====================
    // Divisor select
    always_comb
    begin
        if (!bus.slow)
            lim_next = 5'(`PMV_RUN_DIV - 1);
        else
            lim_next = 5'((5'h4 << bus.sel) - 5'h1);
    end

    // New divisor taken only at wrap, so no short pulse occurs
    always_ff @(posedge i_clk_sys or posedge i_rst)
    begin
        if (i_rst)
        begin
            cnt_reg  <= 5'h0;
            lim_reg  <= 5'h1;
            bus.tick <= 1'b0;
        end
        else if (i_ce)
        begin
            if (!bus.run)
            begin
                cnt_reg  <= 5'h0;
                bus.tick <= 1'b0;
            end
            else if (cnt_reg >= lim_reg)
            begin
                cnt_reg  <= 5'h0;
                lim_reg  <= lim_next;
                bus.tick <= 1'b1;
            end
            else
            begin
                cnt_reg  <= cnt_reg + 5'h1;
                bus.tick <= 1'b0;
            end
        end
    end
endmodule
`default_nettype wire

// ### design/pmv_clkdiv_if.sv
/*
 * Carrier between the controller and its clock divider.
 * Assumes one clock domain.
 */
`timescale 1ns/100ps
`default_nettype none
interface pmv_clkdiv_if;
    logic       run;      // Oscillator on
    logic [1:0] sel;      // Slow divisor select
    logic       slow;     // Slow mode on
    logic       tick;     // One cpu clock tick
    modport ctrl (output run, output sel, output slow, input tick);
    modport div  (input run, input sel, input slow, output tick);
endinterface
`default_nettype wire

// ### design/pmv_ctrl.sv
/*
 * Power mode and vector controller: run, slow, wait, slow-wait and halt,
 * oscillator start-up delay, fixed-priority vector selection and the
 * global interrupt mask. Registers over AXI4-Lite.
 * Assumes the cpu core pulses instruction strobes on the same clock and
 * interrupt sources are already synchronous to i_clk_sys.
 */
// The AXI4-Lite interface to the registers and the register offsets were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
`include "pmv_defs.svh"
module pmv_ctrl
    import pmv_pkg::*;
#(
    parameter int STARTUP_CYCLES = `PMV_STARTUP_OSC_CYCLES
) (
    input  wire logic              i_clk_sys,       // Main oscillator clock
    input  wire logic              i_rst,           // Async reset, active high
    input  wire logic              i_ce,            // Clock enable
    input  wire logic [7:0]        i_awaddr,        // AXI write address
    input  wire logic              i_awvalid,       // AXI write address valid
    output logic                   o_awready,       // AXI write address ready
    input  wire logic [31:0]       i_wdata,         // AXI write data
    input  wire logic [3:0]        i_wstrb,         // AXI write strobes
    input  wire logic              i_wvalid,        // AXI write data valid
    output logic                   o_wready,        // AXI write data ready
    output logic [1:0]             o_bresp,         // AXI write response
    output logic                   o_bvalid,        // AXI write response valid
    input  wire logic              i_bready,        // AXI write response ready
    input  wire logic [7:0]        i_araddr,        // AXI read address
    input  wire logic              i_arvalid,       // AXI read address valid
    output logic                   o_arready,       // AXI read address ready
    output logic [31:0]            o_rdata,         // AXI read data
    output logic [1:0]             o_rresp,         // AXI read response
    output logic                   o_rvalid,        // AXI read data valid
    input  wire logic              i_rready,        // AXI read ready
    input  wire logic              i_wait_for_irq_instr, // Cpu wait instr pulse
    input  wire logic              i_halt_instr,    // Cpu halt instr pulse
    input  wire logic              i_trap_instr,    // Cpu trap instr pulse
    input  wire logic              i_iret_instr,    // Cpu return pulse
    input  wire logic              i_ack,           // Cpu took the vector
    input  wire logic [9:0]        i_irq,           // Sources ext0..sci
    input  wire logic              i_wdg_enabled,   // Watchdog running
    input  wire logic              i_watchdog_stop_compat_option, // Halt allowed
    output logic                   o_cpu_tick,      // Cpu clock enable
    output logic                   o_periph_tick,   // Peripheral clock enable
    output logic                   o_osc_on,        // Oscillator enable
    output logic                   o_cpu_run,       // Cpu executing
    output logic                   o_irq_req,       // Vector request to cpu
    output pmv_pkg::pmv_vec_t      o_vector,        // Service address
    output logic                   o_imask,         // Global interrupt mask
    output logic                   o_wdg_reset,     // Watchdog reset request
    output pmv_pkg::pmv_mode_e     o_mode           // Current mode
);
    import pmv_pkg::*;

    // ====================
    // State
    pmv_clkdiv_if div_bus ();
    pmv_mode_e   mode_reg;
    logic [7:0]  misc_control_reg;
    logic        condition_code_reg;     // Global mask bit
    logic        saved_mask_reg;
    logic        reset_vec_reg;          // Reset vector still owed
    logic        trap_pend_reg;
    logic [12:0] start_cnt_reg;
    logic [`PMV_NSRC-1:0] pend;
    logic [`PMV_NSRC-1:0] takeable;
    logic        have_irq;
    pmv_vec_t    vec_next;
    logic        aw_hold_reg;
    logic        w_hold_reg;
    logic [7:0]  awaddr_reg;
    logic [31:0] wdata_reg;
    logic [3:0]  wstrb_reg;
    logic        wr_fire;

    // ====================
    // Vector selection
    function automatic pmv_vec_t vec_of(input int idx);
        case (idx)
            `PMV_SRC_TRAP:    vec_of = `PMV_VEC_TRAP;
            `PMV_SRC_EXT0:    vec_of = `PMV_VEC_EXT0;
            `PMV_SRC_EXT1:    vec_of = `PMV_VEC_EXT1;
            `PMV_SRC_CSS:     vec_of = `PMV_VEC_CSS;
            `PMV_SRC_SPI:     vec_of = `PMV_VEC_SPI;
            `PMV_SRC_TIM16:   vec_of = `PMV_VEC_TIM16;
            `PMV_SRC_ART_IC:  vec_of = `PMV_VEC_ART_IC;
            `PMV_SRC_ART_OVF: vec_of = `PMV_VEC_ART_OVF;
            `PMV_SRC_AMP1:    vec_of = `PMV_VEC_AMP1;
            `PMV_SRC_AMP2:    vec_of = `PMV_VEC_AMP2;
            default:          vec_of = `PMV_VEC_SCI;
        endcase
    endfunction

    assign pend = {i_irq, trap_pend_reg};
    // Trap ignores the mask, maskables need it clear
    assign takeable = {i_irq & {10{~condition_code_reg}}, trap_pend_reg};
    assign have_irq = |takeable;

    always_comb
    begin
        vec_next = `PMV_VEC_SCI;
        for (int k = `PMV_NSRC - 1; k >= 0; k--)
        begin
            if (takeable[k])
                vec_next = vec_of(k);
        end
        if (reset_vec_reg)
            vec_next = `PMV_VEC_RESET;
    end

    // ====================
    // Clock divider
    assign div_bus.run  = (mode_reg != PMV_HALT);
    assign div_bus.slow = misc_control_reg[`PMV_SLOW_ENABLE_BIT];
    assign div_bus.sel  = {misc_control_reg[`PMV_DIV_SEL_HI_BIT],
                           misc_control_reg[`PMV_DIV_SEL_LO_BIT]};

    pmv_clkdiv u_div (
        .i_clk_sys (i_clk_sys),
        .i_rst     (i_rst),
        .i_ce      (i_ce),
        .bus       (div_bus)
    );

    // ====================
    // Mode machine
    always_ff @(posedge i_clk_sys or posedge i_rst)
    begin
        if (i_rst)
        begin
            mode_reg      <= PMV_STARTUP; // reset also runs start-up
            start_cnt_reg <= 13'h0;
            o_wdg_reset   <= 1'b0;
        end
        else if (i_ce)
        begin
            o_wdg_reset <= 1'b0;
            case (mode_reg)
                PMV_RUN, PMV_SLOW:
                begin
                    if (i_halt_instr && i_wdg_enabled && !i_watchdog_stop_compat_option)
                        o_wdg_reset <= 1'b1;
                    else if (i_halt_instr && (pend != '0))
                    begin
                        // Pending request wakes at once
                        mode_reg      <= PMV_STARTUP;
                        start_cnt_reg <= 13'h0;
                    end
                    else if (i_halt_instr)
                        mode_reg <= PMV_HALT;
                    else if (i_wait_for_irq_instr)
                        mode_reg <= div_bus.slow ? PMV_SLOW_WAIT : PMV_WAIT;
                    else
                        mode_reg <= div_bus.slow ? PMV_SLOW : PMV_RUN;
                end
                PMV_WAIT, PMV_SLOW_WAIT:
                begin
                    if (have_irq)
                        mode_reg <= div_bus.slow ? PMV_SLOW : PMV_RUN;
                    else
                        mode_reg <= div_bus.slow ? PMV_SLOW_WAIT : PMV_WAIT;
                end
                PMV_HALT:
                begin
                    if ((pend & `PMV_HALT_WAKE_MASK) != '0)
                    begin
                        mode_reg      <= PMV_STARTUP;
                        start_cnt_reg <= 13'h0;
                    end
                end
                default:
                begin
                    // Oscillator restarted, count cpu cycles in osc cycles
                    if (start_cnt_reg == 13'(STARTUP_CYCLES - 1))
                        mode_reg <= div_bus.slow ? PMV_SLOW : PMV_RUN;
                    else
                        start_cnt_reg <= start_cnt_reg + 13'h1;
                end
            endcase
        end
    end

    // ====================
    // Mask bit, trap latch and vector request
    always_ff @(posedge i_clk_sys or posedge i_rst)
    begin
        if (i_rst)
        begin
            condition_code_reg <= 1'b1;
            saved_mask_reg     <= 1'b1;
            reset_vec_reg      <= 1'b1;
            trap_pend_reg      <= 1'b0;
            o_irq_req          <= 1'b0;
            o_vector           <= `PMV_VEC_RESET;
        end
        else if (i_ce)
        begin
            if (i_trap_instr)
                trap_pend_reg <= 1'b1;
            if ((mode_reg == PMV_RUN || mode_reg == PMV_SLOW) && !i_halt_instr &&
                i_wait_for_irq_instr)
                condition_code_reg <= 1'b0;
            if ((mode_reg == PMV_RUN || mode_reg == PMV_SLOW) && i_halt_instr)
                condition_code_reg <= 1'b0;
            if (i_iret_instr)
                condition_code_reg <= saved_mask_reg;
            o_irq_req <= 1'b0;
            if ((mode_reg == PMV_RUN || mode_reg == PMV_SLOW) &&
                (reset_vec_reg || have_irq) && !i_ack)
            begin
                o_irq_req <= 1'b1;
                o_vector  <= vec_next;
            end
            if (i_ack && o_irq_req)
            begin
                if (o_vector == `PMV_VEC_RESET)
                    reset_vec_reg <= 1'b0;
                else
                begin
                    saved_mask_reg     <= condition_code_reg;
                    condition_code_reg <= 1'b1;
                end
                if (o_vector == `PMV_VEC_TRAP && !i_trap_instr)
                    trap_pend_reg <= 1'b0;
            end
        end
    end

    // ====================
    // Outputs from flops
    always_ff @(posedge i_clk_sys or posedge i_rst)
    begin
        if (i_rst)
        begin
            o_cpu_tick    <= 1'b0;
            o_periph_tick <= 1'b0;
            o_osc_on      <= 1'b1;
            o_cpu_run     <= 1'b0;
            o_imask       <= 1'b1;
            o_mode        <= PMV_STARTUP;
        end
        else if (i_ce)
        begin
            o_cpu_tick    <= div_bus.tick && (mode_reg == PMV_RUN || mode_reg == PMV_SLOW);
            o_periph_tick <= div_bus.tick && !(mode_reg inside {PMV_STARTUP, PMV_HALT});
            o_osc_on      <= (mode_reg != PMV_HALT);
            o_cpu_run     <= (mode_reg == PMV_RUN || mode_reg == PMV_SLOW);
            o_imask       <= condition_code_reg;
            o_mode        <= mode_reg;
        end
    end

    // ====================
    // AXI4-Lite slave; address and data taken in either order
    assign wr_fire = aw_hold_reg && w_hold_reg && !o_bvalid;

    always_ff @(posedge i_clk_sys or posedge i_rst)
    begin
        if (i_rst)
        begin
            aw_hold_reg      <= 1'b0;
            w_hold_reg       <= 1'b0;
            awaddr_reg       <= 8'h0;
            wdata_reg        <= 32'h0;
            wstrb_reg        <= 4'h0;
            o_awready        <= 1'b1;
            o_wready         <= 1'b1;
            o_bvalid         <= 1'b0;
            o_bresp          <= 2'h0;
            misc_control_reg <= `PMV_MISC_RST;
        end
        else if (i_ce)
        begin
            if (i_awvalid && o_awready)
            begin
                aw_hold_reg <= 1'b1;
                awaddr_reg  <= i_awaddr;
                o_awready   <= 1'b0;
            end
            if (i_wvalid && o_wready)
            begin
                w_hold_reg <= 1'b1;
                wdata_reg  <= i_wdata;
                wstrb_reg  <= i_wstrb;
                o_wready   <= 1'b0;
            end
            if (wr_fire)
            begin
                aw_hold_reg <= 1'b0;
                w_hold_reg  <= 1'b0;
                o_bvalid    <= 1'b1;
                o_bresp     <= 2'h0;
                if (awaddr_reg[7:2] == `PMV_MISC_ADDR >> 2)
                begin
                    if (wstrb_reg[0])
                        misc_control_reg <= wdata_reg[7:0];
                end
                else
                    o_bresp <= 2'h2;
            end
            if (o_bvalid && i_bready)
            begin
                o_bvalid  <= 1'b0;
                o_awready <= 1'b1;
                o_wready  <= 1'b1;
            end
        end
    end

    always_ff @(posedge i_clk_sys or posedge i_rst)
    begin
        if (i_rst)
        begin
            o_arready <= 1'b1;
            o_rvalid  <= 1'b0;
            o_rdata   <= 32'h0;
            o_rresp   <= 2'h0;
        end
        else if (i_ce)
        begin
            if (i_arvalid && o_arready)
            begin
                o_arready <= 1'b0;
                o_rvalid  <= 1'b1;
                o_rresp   <= 2'h0;
                if (i_araddr[7:2] == `PMV_MISC_ADDR >> 2)
                    o_rdata <= {24'h0, misc_control_reg};
                else if (i_araddr[7:2] == `PMV_MODE_ADDR >> 2)
                    o_rdata <= {27'h0, condition_code_reg, 1'b0, mode_reg};
                else if (i_araddr[7:2] == `PMV_IRQ_ADDR >> 2)
                    o_rdata <= {21'h0, pend};
                else
                begin
                    o_rdata <= 32'h0;
                    o_rresp <= 2'h2;
                end
            end
            if (o_rvalid && i_rready)
            begin
                o_rvalid  <= 1'b0;
                o_arready <= 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

// ### design/pmv_defs.svh
/*
 * Constants of the power mode and vector controller: register map,
 * field positions, reset values, vector addresses and timing counts.
 * Assumes it is included by bare name from design files.
 */
`ifndef PMV_DEFS_SVH
`define PMV_DEFS_SVH

// ====================
// Register map (byte addresses on AXI4-Lite)
`define PMV_MISC_ADDR      8'h20
`define PMV_MODE_ADDR      8'h24
`define PMV_IRQ_ADDR       8'h2c
`define PMV_MISC_RST       8'h00

// ====================
// Field positions in misc_control_reg
`define PMV_SLOW_ENABLE_BIT   0
`define PMV_DIV_SEL_LO_BIT    1
`define PMV_DIV_SEL_HI_BIT    2

// ====================
// Vector addresses, high byte first in memory
`define PMV_VEC_RESET      16'hfffe
`define PMV_VEC_TRAP       16'hfffc
`define PMV_VEC_EXT0       16'hfffa
`define PMV_VEC_EXT1       16'hfff8
`define PMV_VEC_CSS        16'hfff6
`define PMV_VEC_SPI        16'hfff4
`define PMV_VEC_TIM16      16'hfff2
`define PMV_VEC_ART_IC     16'hfff0
`define PMV_VEC_ART_OVF    16'hffee
`define PMV_VEC_AMP1       16'hffec
`define PMV_VEC_AMP2       16'hffea
`define PMV_VEC_SCI        16'hffe4

// ====================
// Interrupt source indices, 0 is highest priority after reset
`define PMV_NSRC           11
`define PMV_SRC_TRAP       0
`define PMV_SRC_EXT0       1
`define PMV_SRC_EXT1       2
`define PMV_SRC_CSS        3
`define PMV_SRC_SPI        4
`define PMV_SRC_TIM16      5
`define PMV_SRC_ART_IC     6
`define PMV_SRC_ART_OVF    7
`define PMV_SRC_AMP1       8
`define PMV_SRC_AMP2       9
`define PMV_SRC_SCI        10
// Sources able to leave halt: ext0, ext1, art, amp
`define PMV_HALT_WAKE_MASK 11'h3c6

// ====================
// Timing
`define PMV_RUN_DIV        2
`define PMV_STARTUP_CPU_CYCLES 4096
`define PMV_STARTUP_OSC_CYCLES (`PMV_STARTUP_CPU_CYCLES * `PMV_RUN_DIV)

`endif

// ### design/pmv_pkg.sv
/*
 * Types shared by the power mode and vector controller.
 * Assumes pmv_defs.svh supplies all numeric constants.
 */
package pmv_pkg;
    typedef enum logic [2:0] {
        PMV_RUN       = 3'h0,
        PMV_SLOW      = 3'h1,
        PMV_WAIT      = 3'h2,
        PMV_SLOW_WAIT = 3'h3,
        PMV_HALT      = 3'h4,
        PMV_STARTUP   = 3'h5
    } pmv_mode_e;
    typedef logic [15:0] pmv_vec_t;
endpackage

// ### tb/pmv_cpu_model.sv
/*
 * Cpu core model: one-cycle instruction and acknowledge strobes.
 * Assumes one caller at a time, on i_clk_sys.
 */
`timescale 1ns/100ps
`default_nettype none
module pmv_cpu_model (
    input  wire logic i_clk_sys, // Clock
    output logic      o_wfi,     // Wait
    output logic      o_halt,    // Halt
    output logic      o_trap,    // Trap
    output logic      o_iret,    // Return
    output logic      o_ack      // Vector taken
);
    logic [4:0] p = 5'h0;
    assign {o_ack, o_iret, o_trap, o_halt, o_wfi} = p;
    // Strobes never overlap: the core retires one instruction at a time
    task pulse(input int k);
        @(posedge i_clk_sys);
        p[k] <= 1'b1;
        @(posedge i_clk_sys);
        p[k] <= 1'b0;
    endtask
endmodule
`default_nettype wire

// ### tb/pmv_ctrl_bench.sv
/*
 * Bench for pmv_ctrl: AXI4-Lite tasks and a cpu model.
 * Assumes a 25 MHz clock and a start-up count of 16.
 */
`timescale 1ns/100ps
`default_nettype none
`include "pmv_defs.svh"
module pmv_ctrl_bench;
    import pmv_pkg::*;
    logic        i_clk_sys = 1'b0, i_rst = 1'b1, i_awvalid = 1'b0, i_wvalid = 1'b0;
    logic        i_bready = 1'b0, i_arvalid = 1'b0, i_rready = 1'b0, i_ce = 1'b1;
    logic        i_wdg_enabled = 1'b0, i_watchdog_stop_compat_option = 1'b0;
    logic [3:0]  i_wstrb = 4'hf;
    logic [7:0]  i_awaddr = 8'h0, i_araddr = 8'h0;
    logic [31:0] i_wdata = 32'h0, o_rdata;
    logic [9:0]  i_irq = 10'h0;
    logic [1:0]  o_bresp, o_rresp;
    logic        o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_cpu_tick, o_osc_on;
    logic        o_imask, o_irq_req, o_wdg_reset, i_wait_for_irq_instr, i_halt_instr;
    logic        i_trap_instr, i_iret_instr, i_ack;
    pmv_vec_t    o_vector;
    pmv_mode_e   o_mode;
    int          fail_count = 0, n_checks = 0, i, n;
    always #20 i_clk_sys = ~i_clk_sys;
    pmv_ctrl #(.STARTUP_CYCLES(16)) u_pmv_ctrl (
        .i_clk_sys, .i_rst, .i_ce, .i_awaddr, .i_awvalid, .o_awready, .i_wdata, .i_wstrb,
        .i_wvalid, .o_wready, .o_bresp, .o_bvalid, .i_bready, .i_araddr, .i_arvalid,
        .o_arready, .o_rdata, .o_rresp, .o_rvalid, .i_rready, .i_wait_for_irq_instr,
        .i_halt_instr, .i_trap_instr, .i_iret_instr, .i_ack, .i_irq, .i_wdg_enabled,
        .i_watchdog_stop_compat_option, .o_cpu_tick, .o_periph_tick(), .o_osc_on,
        .o_cpu_run(), .o_irq_req, .o_vector, .o_imask, .o_wdg_reset, .o_mode
    );
    pmv_cpu_model u_pmv_cpu_model (
        .i_clk_sys, .o_wfi(i_wait_for_irq_instr), .o_halt(i_halt_instr),
        .o_trap(i_trap_instr), .o_iret(i_iret_instr), .o_ack(i_ack)
    );
    // ====================
    // Tasks
    task wrap_up();
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        n_checks++;
        if (g !== e)
        begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask
    task lost(input string nm);
        chk(nm, 16'h1, 16'h0);
        wrap_up();
    endtask
    // Kinds: 0 mode reached, 1 vector request, 2 watchdog reset pulse
    task wt(input int w, input pmv_mode_e m);
        for (n = 0; n < 200; n++)
        begin
            @(posedge i_clk_sys);
            if ((w == 0 && o_mode === m) || (w == 1 && o_irq_req === 1'b1)
                || (w == 2 && o_wdg_reset === 1'b1))
                return;
        end
        lost("wait");
    endtask
    task wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] r);
        @(posedge i_clk_sys);
        i_awaddr <= a;
        i_wdata <= {24'h0, d};
        i_awvalid <= 1'b1;
        i_wvalid <= 1'b1;
        i_bready <= 1'b1;
        for (n = 0; n < 50 && o_bvalid !== 1'b1; n++)
        begin
            @(posedge i_clk_sys);
            if (o_awready === 1'b1)
                i_awvalid <= 1'b0;
            if (o_wready === 1'b1)
                i_wvalid <= 1'b0;
        end
        i_bready <= 1'b0;
        if (n == 50)
            lost("bvalid");
        chk("bresp", 16'(r), 16'(o_bresp));
    endtask
    task rd(input logic [7:0] a, input logic [7:0] d, input logic [1:0] r);
        @(posedge i_clk_sys);
        i_araddr <= a;
        i_arvalid <= 1'b1;
        i_rready <= 1'b1;
        for (n = 0; n < 50 && o_rvalid !== 1'b1; n++)
        begin
            @(posedge i_clk_sys);
            if (o_arready === 1'b1)
                i_arvalid <= 1'b0;
        end
        i_rready <= 1'b0;
        if (n == 50)
            lost("rvalid");
        chk("rresp", 16'(r), 16'(o_rresp));
        if (r == 2'h0)
            chk("rdata", 16'(d), o_rdata[15:0]);
    endtask
    // Third tick interval is clear of any divisor change in flight
    task gap();
        repeat (3)
        begin
            n = 0;
            do
            begin
                @(posedge i_clk_sys);
                n++;
            end
            while (o_cpu_tick !== 1'b1 && n < 99);
        end
    endtask
    // ====================
    // Sequence; cpu strobes 0 wait, 1 halt, 2 trap, 3 return, 4 ack
    initial
    begin
        repeat (20) @(posedge i_clk_sys);
        i_rst <= 1'b0;
        wt(1, PMV_RUN);
        chk("vector", `PMV_VEC_RESET, o_vector);
        chk("mode", 16'(PMV_RUN), 16'(o_mode));
        u_pmv_cpu_model.pulse(4);
        u_pmv_cpu_model.pulse(2);
        wt(1, PMV_RUN);
        chk("vector", `PMV_VEC_TRAP, o_vector);
        u_pmv_cpu_model.pulse(4);
        rd(`PMV_MISC_ADDR, 8'h00, 2'h0);
        rd(8'h28, 8'h00, 2'h2);
        for (i = 0; i < 4; i++)
        begin
            wr(`PMV_MISC_ADDR, 8'(i * 2 + 1), 2'h0);
            gap();
            chk("divisor", 16'(4 << i), 16'(n));
        end
        i_wstrb <= 4'h0;
        wr(`PMV_MISC_ADDR, 8'h00, 2'h0);
        i_wstrb <= 4'hf;
        rd(`PMV_MISC_ADDR, 8'h07, 2'h0);
        u_pmv_cpu_model.pulse(0);
        wt(0, PMV_SLOW_WAIT);
        chk("imask", 16'h0, 16'(o_imask));
        i_irq <= 10'h200;
        wt(1, PMV_RUN);
        chk("vector", `PMV_VEC_SCI, o_vector);
        u_pmv_cpu_model.pulse(4);
        i_irq <= 10'h0;
        repeat (2) @(posedge i_clk_sys);
        chk("imask", 16'h1, 16'(o_imask));
        u_pmv_cpu_model.pulse(3);
        repeat (2) @(posedge i_clk_sys);
        chk("imask", 16'h0, 16'(o_imask));
        wr(`PMV_MISC_ADDR, 8'h00, 2'h0);
        u_pmv_cpu_model.pulse(1);
        wt(0, PMV_HALT);
        chk("osc", 16'h0, 16'(o_osc_on));
        i_irq <= 10'h004;
        repeat (20) @(posedge i_clk_sys);
        chk("mode", 16'(PMV_HALT), 16'(o_mode));
        i_ce <= 1'b0;
        i_irq <= 10'h205;
        repeat (9) @(posedge i_clk_sys);
        chk("frozen", 16'(PMV_HALT), 16'(o_mode));
        i_ce <= 1'b1;
        wt(0, PMV_STARTUP);
        wt(1, PMV_RUN);
        chk("vector", `PMV_VEC_EXT0, o_vector);
        u_pmv_cpu_model.pulse(4);
        i_irq <= 10'h0;
        u_pmv_cpu_model.pulse(3);
        i_wdg_enabled <= 1'b1;
        u_pmv_cpu_model.pulse(1);
        wt(2, PMV_RUN);
        chk("mode", 16'(PMV_RUN), 16'(o_mode));
        i_watchdog_stop_compat_option <= 1'b1;
        i_irq <= 10'h008;
        u_pmv_cpu_model.pulse(1);
        wt(0, PMV_STARTUP);
        wrap_up();
    end
endmodule
`default_nettype wire

// ### tb/pmv_ctrl_sva.sv
/*
 * Checker for pmv_ctrl: clock division, low-power modes, wake-up, mask.
 * Assumes it is bound to pmv_ctrl and sees only its ports.
 */
`timescale 1ns/100ps
`default_nettype none
module pmv_ctrl_sva
    import pmv_pkg::*;
#(
    parameter int STARTUP_CYCLES = 16
) (
    input  wire logic               i_clk_sys,     // Clock
    input  wire logic               i_rst,         // Reset
    input  wire logic               i_ce,          // Clock enable
    input  wire logic               i_halt_instr,  // Halt
    input  wire logic               i_ack,         // Taken
    input  wire logic [9:0]         i_irq,         // Sources
    input  wire logic               i_wdg_enabled, // Watchdog
    input  wire logic               i_watchdog_stop_compat_option, // Option
    input  wire logic               o_cpu_tick,    // Cpu tick
    input  wire logic               o_periph_tick, // Periph tick
    input  wire logic               o_osc_on,      // Osc
    input  wire logic               o_irq_req,     // Request
    input  wire logic               o_imask,       // Mask
    input  wire logic               o_wdg_reset,   // Wdg reset
    input  wire pmv_pkg::pmv_mode_e o_mode         // Mode
);
    // ====================
    // Start-up length counter
    logic [15:0] su_cnt;
    always_ff @(posedge i_clk_sys or posedge i_rst)
    begin
        if (i_rst)
            su_cnt <= 16'h0;
        else if (i_ce)
            su_cnt <= (o_mode == PMV_STARTUP) ? su_cnt + 16'h1 : 16'h0;
    end
    default clocking dcb @(posedge i_clk_sys);
    endclocking
    default disable iff (i_rst || !i_ce);
    // ====================
    // Properties; halt wakers are ext0, ext1, art and amp
    a_run_gap: assert property (
        o_cpu_tick && o_mode == PMV_RUN |=> !o_cpu_tick ##1 (o_cpu_tick || o_mode != PMV_RUN))
        else $error("run tick gap");
    a_slow_gap: assert property (
        o_cpu_tick && o_mode == PMV_SLOW |=> !o_cpu_tick [*3]) else $error("slow tick gap");
    a_halt_clocks: assert property (
        o_mode == PMV_HALT |-> !o_osc_on && !o_cpu_tick && !o_periph_tick)
        else $error("clock in halt");
    a_wait_mask: assert property (
        (o_mode inside {PMV_WAIT, PMV_SLOW_WAIT}) [*2] |-> !o_imask) else $error("wait mask");
    a_halt_wake: assert property (
        o_mode == PMV_HALT && (i_irq & 10'h1e3) != 10'h0 |-> ##[1:2] o_mode == PMV_STARTUP)
        else $error("no wake");
    a_startup_len: assert property (
        $fell(o_mode == PMV_STARTUP) |-> su_cnt + 2 >= STARTUP_CYCLES
        && su_cnt <= STARTUP_CYCLES + 2) else $error("start-up length");
    a_ack_mask: assert property (
        o_irq_req && i_ack |-> ##2 o_imask) else $error("mask after ack");
    a_wdg_pulse: assert property (
        i_halt_instr && i_wdg_enabled && !i_watchdog_stop_compat_option |-> ##[1:2] o_wdg_reset)
        else $error("no watchdog reset");
    c_slow_wait: cover property (o_mode == PMV_SLOW_WAIT);
    c_wake: cover property (o_mode == PMV_HALT ##1 o_mode == PMV_STARTUP);
    c_wdg: cover property (o_wdg_reset);
endmodule
bind pmv_ctrl pmv_ctrl_sva #(.STARTUP_CYCLES(STARTUP_CYCLES)) u_pmv_ctrl_sva (
    .i_clk_sys, .i_rst, .i_ce, .i_halt_instr, .i_ack, .i_irq, .i_wdg_enabled,
    .i_watchdog_stop_compat_option, .o_cpu_tick, .o_periph_tick, .o_osc_on,
    .o_irq_req, .o_imask, .o_wdg_reset, .o_mode
);
`default_nettype wire
